//--- dv/event_triggered_transfer_controller_bench.sv
// self-checking bench for the event triggered transfer controller
// assumes the data bus partner in mem_model.sv
`timescale 1ns/10ps
`default_nettype none
////////////////////////////////////////////////////////////////////////
module event_triggered_transfer_controller_bench;
   typedef struct {logic [31:0] a; logic [31:0] d; logic [31:0] m;} note_t;
   logic mclk_in, reset_in, wr_in, rd_in, nmi_in, rd_pend;
   logic mem_rd_out, mem_wr_out, busy_out;
   logic [7:0] addr_in, req_in, flag_clr_out, cpu_irq_out;
   logic [31:0] wdata_in, rdata_out, mem_addr_out, mem_wdata_out;
   logic [31:0] mem_rdata_in, src, dst;
   logic [1:0] mem_size_out;
   note_t wq[$];
   note_t rq[$];
   int err_count, checks, seed, k;

   event_triggered_transfer_controller #(.N(8), .PIN_MASK(8'h08)) u_dut (
      .mclk_in(mclk_in),
      .reset_in(reset_in), .addr_in(addr_in), .wdata_in(wdata_in),
      .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
      .req_in(req_in), .nmi_in(nmi_in), .flag_clr_out(flag_clr_out),
      .cpu_irq_out(cpu_irq_out), .mem_addr_out(mem_addr_out),
      .mem_wdata_out(mem_wdata_out), .mem_size_out(mem_size_out),
      .mem_rd_out(mem_rd_out), .mem_wr_out(mem_wr_out),
      .mem_rdata_in(mem_rdata_in), .busy_out(busy_out));
   mem_model u_mem (.mclk_in(mclk_in), .rd_in(mem_rd_out),
      .addr_in(mem_addr_out), .rdata_out(mem_rdata_in));

   initial
   begin
      mclk_in = 1'b0;
      forever #10 mclk_in = ~mclk_in;
   end

   ////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] fd(input logic [31:0] a);
      return {a[15:0], ~a[15:0]};
   endfunction : fd

   task automatic report_and_stop;
      $display("checks %0d errors %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : report_and_stop

   task automatic chk(input string what, input logic [31:0] exp,
                      input logic [31:0] got);
      checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic note(input logic [31:0] a, input logic [31:0] d,
                       input logic [31:0] m);
      wq.push_back('{a: a, d: d, m: m});
   endtask : note

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk_in);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge mclk_in);
      wr_in <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] e,
                     input logic [31:0] m);
      @(posedge mclk_in);
      addr_in <= a;
      rd_in <= 1'b1;
      rq.push_back('{a: {24'h0, a}, d: e, m: m});
      @(posedge mclk_in);
      rd_in <= 1'b0;
   endtask : rd

   task automatic winfo(input int b, input logic [31:0] w0, w1, w2, w3);
      wr(8'h40 + 8'(4 * b), w0);
      wr(8'h41 + 8'(4 * b), w1);
      wr(8'h42 + 8'(4 * b), w2);
      wr(8'h43 + 8'(4 * b), w3);
   endtask : winfo

   // peripheral: raise request, drop it on the clear pulse
   task automatic act(input int i, input bit st, input bit clr,
                      input bit irq);
      int n;
      bit seen;
      int nclr;
      seen = 0;
      nclr = 0;
      @(posedge mclk_in);
      req_in[i] <= 1'b1;
      for (n = 0; n < 40; n++)
      begin
         @(posedge mclk_in);
         if (flag_clr_out[i] === 1'b1)
         begin
            nclr++;
            req_in[i] <= 1'b0;
         end
         if (busy_out === 1'b1)
            seen = 1;
         else if (seen || (!st && n > 14))
            break;
      end
      if (n == 40)
      begin
         err_count++;
         $display("ERROR activation wait ran out");
         report_and_stop();
      end
      chk("started", 32'(st), 32'(seen));
      chk("flag clears", 32'(clr), 32'(nclr));
      chk("cpu irq", 32'(irq), 32'(cpu_irq_out[i]));
      // level source held until the interrupt is seen
      req_in[i] <= 1'b0;
      @(posedge mclk_in);
      @(posedge mclk_in);
      chk("irq released", 32'h0, 32'(cpu_irq_out[i]));
   endtask : act

   ////////////////////////////////////////////////////////////////////
   // result watcher: oldest note against each result
   always @(posedge mclk_in)
   begin : watch
      note_t e;
      if (rd_pend === 1'b1 && rq.size() > 0)
      begin
         e = rq.pop_front();
         chk("read data", e.d & e.m, rdata_out & e.m);
      end
      rd_pend <= rd_in;
      if (mem_wr_out === 1'b1)
      begin
         if (wq.size() == 0)
            chk("spare write", 32'h0, 32'h1);
         else
         begin
            e = wq.pop_front();
            chk("write addr", e.a, mem_addr_out);
            chk("write data", e.d & e.m, mem_wdata_out & e.m);
            chk("write size", e.m == 32'hff ? 32'h0 :
               (e.m == 32'hffff ? 32'h1 : 32'h2), 32'(mem_size_out));
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   initial
   begin
      seed = 63;
      err_count = 0;
      checks = 0;
      reset_in = 1'b1;
      wr_in = 1'b0;
      rd_in = 1'b0;
      nmi_in = 1'b0;
      rd_pend = 1'b0;
      addr_in = 8'h00;
      wdata_in = 32'h0;
      req_in = 8'h00;
      repeat (10) @(posedge mclk_in);
      reset_in <= 1'b0;
      rd(8'h00, 32'h0, 32'h3);
      rd(8'h03, 32'h0, 32'hffff_ffff);
      src = $random(seed);
      dst = $random(seed) & 32'h0000_fff0;
      winfo(0, 32'h2000, src, dst, 32'h0003_0000);
      winfo(1, 32'ha120, src, dst + 32'h100, 32'h0002_0000);
      winfo(2, 32'h2600, src, dst + 32'h200, 32'h0202_0000);
      winfo(3, 32'h2000, src, dst + 32'h300, 32'h0);
      winfo(4, 32'h20c0, src, dst + 32'h400, 32'h0002_0000);
      winfo(5, 32'h2000, src + 32'h1, dst + 32'h500, 32'h0005_0000);
      rd(8'h01, 32'h0, 32'hff);
      wr(8'h01, 32'h1f);
      act(0, 0, 0, 0);
      wr(8'h00, 32'h1);
      // normal byte, fixed source, incrementing destination
      for (k = 0; k < 3; k++)
      begin
         note(dst + 32'(k), fd(src), 32'hff);
         act(0, 1, k < 2, k == 2);
      end
      rd(8'h01, 32'h0, 32'h1);
      // word units, interrupt after each transfer
      for (k = 0; k < 2; k++)
      begin
         note(dst + 32'h100 + 32'(2 * k), fd(src + 32'(2 * k)), 32'hffff);
         act(1, 1, 0, 1);
      end
      rd(8'h01, 32'h0, 32'h2);
      // repeat longword, destination rewinds after two
      for (k = 0; k < 3; k++)
      begin
         note(dst + 32'h200 + 32'(4 * (k % 2)), fd(src), 32'hffff_ffff);
         act(2, 1, 1, 0);
      end
      rd(8'h01, 32'h4, 32'h4);
      // count zero wraps; standby refused while busy
      note(dst + 32'h300, fd(src), 32'hff);
      fork
         act(3, 1, 1, 0);
         begin
            repeat (4) @(posedge mclk_in);
            wr(8'h00, 32'h0);
         end
      join
      rd(8'h00, 32'h1, 32'h1);
      rd(8'h4f, 32'hffff_0000, 32'hffff_0000);
      // chain only when the first counter hits zero
      note(dst + 32'h400, fd(src), 32'hff);
      act(4, 1, 1, 0);
      note(dst + 32'h401, fd(src), 32'hff);
      note(dst + 32'h500, fd(src + 32'h1), 32'hff);
      act(4, 1, 1, 0);
      rd(8'h01, 32'h18, 32'h18);
      // stop request against activation
      @(posedge mclk_in);
      nmi_in <= 1'b1;
      repeat (2) @(posedge mclk_in);
      act(3, 0, 0, 0);
      nmi_in <= 1'b0;
      rd(8'h00, 32'h2, 32'h2);
      wr(8'h00, 32'h3);
      rd(8'h00, 32'h1, 32'h3);
      wr(8'h01, 32'h0);
      wr(8'h00, 32'h0);
      rd(8'h00, 32'h0, 32'h1);
      repeat (4) @(posedge mclk_in);
      chk("writes left", 32'h0, 32'(wq.size()));
      report_and_stop();
   end
endmodule : event_triggered_transfer_controller_bench
`default_nettype wire

//--- dv/mem_model.sv
// memory partner on the data bus of the transfer controller
// assumes a read pulse is answered in the following cycle only
`timescale 1ns/10ps
`default_nettype none
////////////////////////////////////////////////////////////////////////
module mem_model
(
   input wire logic mclk_in,
   input wire logic rd_in,
   input wire logic [31:0] addr_in,
   output logic [31:0] rdata_out
);
   ////////////////////////////////////////////////////////////////////
   // answer derived from the address; toggles when not reading
   initial rdata_out = 32'h0000_0000;
   always @(posedge mclk_in)
   begin
      if (rd_in === 1'b1)
         rdata_out <= {addr_in[15:0], ~addr_in[15:0]};
      else
         rdata_out <= ~rdata_out;
   end
endmodule : mem_model
`default_nettype wire

//--- verilog/activation_arbiter.sv
// qualifies activation requests and the non maskable stop
// assumes request lines are levels synchronous to mclk_in
`timescale 1ns/10ps
`include "xfer_params.svh"
`default_nettype none
module activation_arbiter
   import xfer_pkg::*;
#(
   parameter int N = 8,
   parameter logic [N-1:0] PIN_MASK = '0
)
(
   input wire logic mclk_in,
   input wire logic reset_in,
   input wire logic [N-1:0] req_in,
   input wire logic [N-1:0] en_in,
   input wire logic nmi_in,
   output logic valid_out,
   output logic [$clog2(N)-1:0] idx_out,
   output logic nmi_stop_out
);
   localparam int D = `PIN_CYC;
   localparam int S = `NMI_STOP_CYC;

   typedef struct packed {
      logic [N-1:0][D-1:0] hist;
      logic [S-1:0] nmi;
   } arb_t;

   arb_t s;
   arb_t n;
   logic [N-1:0] q;

   if (D < 2 || `PER_CYC > D || N < 2)
      $error("activation_arbiter cannot serve these settings");

   ////////////////////////////////////////////////////////////////////
   // per source history; pin two cycles, peripheral one
   for (genvar i = 0; i < N; i++)
   begin : g_src
      assign q[i] = req_in[i] && en_in[i] && (PIN_MASK[i] ?
         &s.hist[i] : &s.hist[i][`PER_CYC-1:0]);
   end

   always_comb
   begin
      n = s;
      for (int i = 0; i < N; i++)
         n.hist[i] = {s.hist[i][D-2:0], req_in[i] & en_in[i]};
      n.nmi = {s.nmi[S-2:0], nmi_in};
      valid_out = |q;
      idx_out = '0;
      for (int i = N - 1; i >= 0; i--)
         if (q[i])
            idx_out = ($clog2(N))'(i);
   end

   assign nmi_stop_out = s.nmi[S-1];

   always_ff @(posedge mclk_in)
   begin
      if (reset_in)
         s <= '0;
      else
         s <= n;
   end

   ////////////////////////////////////////////////////////////////////
   pin_delay_a: assert property (@(posedge mclk_in) disable iff (reset_in)
      valid_out && ((PIN_MASK & q) != '0) |-> $past(req_in, 2) != '0)
      else $error("pin request taken too early");
endmodule : activation_arbiter
`default_nettype wire

//--- verilog/event_triggered_transfer_controller.sv
// event triggered transfer controller: register port, info memory,
// transfer sequencer; assumes a memory port answering one cycle later
//
// The placing of the registers and the address-and-strobe port were left to the implementer.
`timescale 1ns/10ps
`include "xfer_params.svh"
`default_nettype none
module event_triggered_transfer_controller
   import xfer_pkg::*;
#(
   parameter int N = 8,
   parameter int NB = 16,
   parameter logic [N-1:0] PIN_MASK = '0,
   parameter logic [N-1:0] SELF_CLR = '0
)
(
   input wire logic mclk_in,
   input wire logic reset_in,
   input wire logic [7:0] addr_in,
   input wire logic [31:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [31:0] rdata_out,
   input wire logic [N-1:0] req_in,
   input wire logic nmi_in,
   output logic [N-1:0] flag_clr_out,
   output logic [N-1:0] cpu_irq_out,
   output logic [31:0] mem_addr_out,
   output logic [31:0] mem_wdata_out,
   output logic [1:0] mem_size_out,
   output logic mem_rd_out,
   output logic mem_wr_out,
   input wire logic [31:0] mem_rdata_in,
   output logic busy_out
);
   localparam int SW = $clog2(N);
   localparam int BW = $clog2(NB);
   localparam int RAW = BW + 2;

   typedef struct packed {
      xfer_state_t st;
      logic run;
      logic err;
      logic chain;
      logic hit;
      logic [N-1:0] en;
      logic [N-1:0] pass;
      logic [N-1:0] clr;
      logic [SW-1:0] src;
      logic [BW-1:0] blk;
      logic [1:0] wi;
      logic [7:0] mode_reg_a;
      logic [7:0] mode_reg_b;
      logic [31:0] sp;
      logic [31:0] dp;
      logic [15:0] ca;
      logic [15:0] cb;
      logic [RAW-1:0] raddr;
      logic rwe;
      logic [31:0] rwd;
      logic mrd;
      logic mwr;
      logic [31:0] maddr;
      logic [31:0] mwd;
      logic [31:0] rdat;
      logic rsel;
   } state_t;

   state_t s;
   state_t n;
   logic arb_valid;
   logic [SW-1:0] arb_idx;
   logic nmi_stop;
   logic [31:0] ram_qa;
   logic [31:0] ram_qb;
   logic [31:0] u;
   logic [31:0] rw;
   logic go_chain;

   if (N < 2 || NB < N || NB > 32)
      $error("controller cannot serve these source or block counts");

   ////////////////////////////////////////////////////////////////////
   // helpers
   function automatic logic is_info(input logic [7:0] a);
      return a >= `INFO_BASE && a < 8'(`INFO_BASE + 4 * NB);
   endfunction : is_info

   function automatic logic [31:0] unit(input logic [1:0] sz);
      if (sz == `SZ_LONG)
         return 32'h4;
      else if (sz == `SZ_WORD)
         return 32'h2;
      else
         return 32'h1;
   endfunction : unit

   function automatic logic [31:0] adv(input logic [31:0] p,
      input logic [1:0] m, input logic [31:0] amt);
      if (m == `AM_INC)
         return p + amt;
      else if (m == `AM_DEC)
         return p - amt;
      else
         return p;
   endfunction : adv

   ////////////////////////////////////////////////////////////////////
   // submodules
   activation_arbiter #(.N(N), .PIN_MASK(PIN_MASK)) u_arb (
      .mclk_in(mclk_in),
      .reset_in(reset_in),
      .req_in(req_in),
      .en_in(s.en & ~s.pass),
      .nmi_in(nmi_in),
      .valid_out(arb_valid),
      .idx_out(arb_idx),
      .nmi_stop_out(nmi_stop)
   );

   info_ram #(.DEPTH(4 * NB), .AW(RAW)) u_ram (
      .mclk_in(mclk_in),
      .a_addr_in(RAW'(addr_in - `INFO_BASE)),
      .a_we_in(wr_in && is_info(addr_in)),
      .a_wd_in(wdata_in),
      .a_rd_out(ram_qa),
      .b_addr_in(n.raddr),
      .b_we_in(n.rwe),
      .b_wd_in(n.rwd),
      .b_rd_out(ram_qb)
   );

   ////////////////////////////////////////////////////////////////////
   // next state
   assign u = unit(s.mode_reg_a[`MRA_SZ]);
   assign rw = 32'(s.ca[15:8]) * u;
   assign go_chain = s.mode_reg_b[`MRB_CHAIN] &&
      (!s.mode_reg_b[`MRB_ON_ZERO] || s.hit);

   always_comb
   begin
      n = s;
      n.clr = '0;
      n.rwe = 1'b0;
      n.mrd = 1'b0;
      n.mwr = 1'b0;
      n.pass = s.pass & req_in;
      if (wr_in)
      begin
         if (addr_in == `REG_CTRL)
         begin
            if (wdata_in[`CTRL_RUN] || s.st == IDLE)
               n.run = wdata_in[`CTRL_RUN];
            if (wdata_in[`CTRL_ERR])
               n.err = 1'b0;
         end
         else if (addr_in == `REG_EN)
            n.en = wdata_in[N-1:0];
      end
      if (rd_in)
      begin
         n.rsel = is_info(addr_in);
         if (addr_in == `REG_CTRL)
            n.rdat = {30'h0, s.err, s.run};
         else if (addr_in == `REG_EN)
            n.rdat = 32'(s.en);
         else if (addr_in == `REG_STAT)
            n.rdat = {23'h0, 8'(s.src), s.st != IDLE};
         else
            n.rdat = 32'h0;
      end
      case (s.st)
         IDLE:
         begin
            if (s.run && arb_valid)
            begin
               if (nmi_stop)
                  n.err = 1'b1;
               else
               begin
                  n.st = RD_INFO;
                  n.src = arb_idx;
                  n.blk = BW'(arb_idx);
                  n.raddr = {BW'(arb_idx), 2'h0};
                  n.wi = 2'h0;
               end
            end
         end
         RD_INFO:
         begin
            case (s.wi)
               2'h0:
               begin
                  n.mode_reg_a = ram_qb[15:8];
                  n.mode_reg_b = ram_qb[7:0];
               end
               2'h1: n.sp = ram_qb;
               2'h2: n.dp = ram_qb;
               default:
               begin
                  n.ca = ram_qb[31:16];
                  n.cb = ram_qb[15:0];
               end
            endcase
            n.wi = s.wi + 2'h1;
            n.raddr = {s.blk, s.wi + 2'h1};
            if (s.wi == 2'h3)
            begin
               n.st = DATA_WAIT;
               n.mrd = 1'b1;
               n.maddr = s.sp;
            end
         end
         DATA_WAIT:
            n.st = DATA_CAP;
         DATA_CAP:
         begin
            n.mwr = 1'b1;
            n.maddr = s.dp;
            n.mwd = mem_rdata_in;
            n.sp = adv(s.sp, s.mode_reg_a[`MRA_SM], u);
            n.dp = adv(s.dp, s.mode_reg_a[`MRA_DM], u);
            n.st = STEP;
            n.hit = 1'b0;
            if (s.mode_reg_a[`MRA_MD] == `MD_REPEAT || s.mode_reg_a[`MRA_MD] == `MD_BLOCK)
            begin
               n.ca[7:0] = s.ca[7:0] - 8'h1;
               if (s.ca[7:0] == 8'h1)
               begin
                  n.ca[7:0] = s.ca[15:8];
                  if (s.mode_reg_b[`MRB_REP_SIDE])
                     n.sp = adv(n.sp, s.mode_reg_a[`MRA_SM] ^ 2'h1, rw);
                  else
                     n.dp = adv(n.dp, s.mode_reg_a[`MRA_DM] ^ 2'h1, rw);
                  if (s.mode_reg_a[`MRA_MD] == `MD_BLOCK)
                  begin
                     n.cb = s.cb - 16'h1;
                     n.hit = s.cb == 16'h1;
                  end
               end
               else if (s.mode_reg_a[`MRA_MD] == `MD_BLOCK)
               begin
                  n.st = DATA_WAIT;
                  n.mrd = 1'b1;
                  n.maddr = n.sp;
               end
            end
            else
            begin
               n.ca = s.ca - 16'h1;
               n.hit = s.ca == 16'h1;
            end
         end
         STEP:
         begin
            n.chain = go_chain;
            if (!go_chain)
            begin
               if (s.hit)
               begin
                  n.en[s.src] = 1'b0;
                  n.pass[s.src] = 1'b1;
               end
               else if (s.mode_reg_b[`MRB_EACH_IRQ])
                  n.pass[s.src] = 1'b1;
               else if (!SELF_CLR[s.src])
                  n.clr[s.src] = 1'b1;
            end
            n.rwe = 1'b1;
            n.raddr = {s.blk, 2'h1};
            n.rwd = s.sp;
            n.wi = 2'h2;
            n.st = WB;
         end
         WB:
         begin
            if (s.wi == 2'h0)
            begin
               n.raddr = {s.blk, 2'h0};
               n.st = RD_INFO;
            end
            else
            begin
               n.rwe = 1'b1;
               n.raddr = {s.blk, s.wi};
               n.rwd = (s.wi == 2'h2) ? s.dp : {s.ca, s.cb};
               n.wi = 2'h3;
               if (s.wi == 2'h3)
               begin
                  if (s.chain)
                  begin
                     n.blk = s.blk + BW'(1);
                     n.wi = 2'h0;
                  end
                  else
                     n.st = IDLE;
               end
            end
         end
         default:
            n.st = IDLE;
      endcase
   end

   always_ff @(posedge mclk_in)
   begin
      if (reset_in)
         s <= '0;
      else
         s <= n;
   end

   ////////////////////////////////////////////////////////////////////
   // outputs
   assign rdata_out = s.rsel ? ram_qa : s.rdat;
   assign flag_clr_out = s.clr;
   assign cpu_irq_out = req_in & (~s.en | s.pass);
   assign mem_addr_out = s.maddr;
   assign mem_wdata_out = s.mwd;
   assign mem_size_out = s.mode_reg_a[`MRA_SZ];
   assign mem_rd_out = s.mrd;
   assign mem_wr_out = s.mwr;
   assign busy_out = s.st != IDLE;

   ////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb_main @(posedge mclk_in);
   endclocking
   default disable iff (reset_in);

   sequence wb_tail;
      s.st == WB [*2] ##1 s.st == IDLE;
   endsequence

   count_step_a: assert property (s.st == DATA_CAP &&
      s.mode_reg_a[`MRA_MD] == 2'h0 |=> s.ca == $past(s.ca) - 16'h1)
      else $error("normal count did not step down");
   dest_step_a: assert property (s.st == DATA_CAP &&
      s.mode_reg_a[`MRA_DM] == `AM_INC && (s.mode_reg_a[`MRA_MD] == 2'h0 ||
      s.ca[7:0] != 8'h1 || s.mode_reg_b[`MRB_REP_SIDE])
      |=> s.dp == $past(s.dp) + $past(u))
      else $error("destination did not advance by unit");
   dest_rewind_a: assert property (s.st == DATA_CAP &&
      s.mode_reg_a[`MRA_DM] == `AM_INC && s.mode_reg_a[`MRA_MD] == `MD_REPEAT &&
      s.ca[7:0] == 8'h1 && !s.mode_reg_b[`MRB_REP_SIDE]
      |=> s.dp == $past(s.dp) + $past(u) - $past(rw))
      else $error("repeat destination did not rewind");
   single_done_a: assert property (s.st == STEP && !go_chain
      |-> ##1 wb_tail)
      else $error("writeback did not end the activation");
   zero_end_a: assert property (s.st == STEP && !go_chain &&
      s.hit |=> !s.en[$past(s.src)] && !s.clr[$past(s.src)])
      else $error("count end did not drop the enable");
   repeat_quiet_a: assert property (s.st == STEP &&
      s.mode_reg_a[`MRA_MD] == `MD_REPEAT && !s.mode_reg_b[`MRB_EACH_IRQ]
      && !$past(s.pass[s.src]) |=> !s.pass[$past(s.src)])
      else $error("repeat mode raised an interrupt");
   chain_keep_a: assert property (s.st == STEP && go_chain
      |=> s.clr == '0 && s.en == $past(s.en))
      else $error("chain cleared its source early");
   standby_hold_a: assert property (!s.run && s.st == IDLE
      |=> s.st == IDLE)
      else $error("transfer started in standby");
   stop_wins_a: assert property (s.st == IDLE && s.run &&
      arb_valid && nmi_stop |=> s.st == IDLE && s.err)
      else $error("stop did not block activation");
   busy_src_a: assert property (s.st != IDLE && $past(s.st) != IDLE
      |-> s.src == $past(s.src))
      else $error("new activation taken while busy");
endmodule : event_triggered_transfer_controller
`default_nettype wire

//--- verilog/info_ram.sv
// dual port transfer information memory, registered read data
// assumes both ports on one clock; port b wins a write clash
`timescale 1ns/10ps
`default_nettype none
module info_ram
#(
   parameter int DEPTH = 64,
   parameter int AW = 6
)
(
   input wire logic mclk_in,
   input wire logic [AW-1:0] a_addr_in,
   input wire logic a_we_in,
   input wire logic [31:0] a_wd_in,
   output logic [31:0] a_rd_out,
   input wire logic [AW-1:0] b_addr_in,
   input wire logic b_we_in,
   input wire logic [31:0] b_wd_in,
   output logic [31:0] b_rd_out
);
   logic [31:0] mem [DEPTH];

   if (DEPTH != (1 << AW))
      $error("info_ram depth must be two to the address width");

   always_ff @(posedge mclk_in)
   begin
      if (a_we_in)
         mem[a_addr_in] <= a_wd_in;
      if (b_we_in)
         mem[b_addr_in] <= b_wd_in;
      a_rd_out <= mem[a_addr_in];
      b_rd_out <= mem[b_addr_in];
   end
endmodule : info_ram
`default_nettype wire

//--- verilog/xfer_params.svh
// constants for the event triggered transfer controller
// assumes one 50 MHz clock; bus and peripheral cycles equal it
`ifndef XFER_PARAMS_SVH
`define XFER_PARAMS_SVH
`define REG_CTRL 8'h00
`define REG_EN 8'h01
`define REG_STAT 8'h02
`define INFO_BASE 8'h40
`define CTRL_RUN 0
`define CTRL_ERR 1
`define MRA_SM 7:6
`define MRA_DM 5:4
`define MRA_MD 3:2
`define MRA_SZ 1:0
`define MRB_CHAIN 7
`define MRB_ON_ZERO 6
`define MRB_EACH_IRQ 5
`define MRB_REP_SIDE 4
`define AM_INC 2'h2
`define AM_DEC 2'h3
`define MD_REPEAT 2'h1
`define MD_BLOCK 2'h2
`define SZ_WORD 2'h1
`define SZ_LONG 2'h2
`define CLK_NS 20
`define BCYC_NS 20
`define PCYC_NS 20
`define NMI_STOP_CYC ((1*`BCYC_NS+3*`PCYC_NS+`CLK_NS-1)/`CLK_NS)
`define PIN_CYC ((2*`BCYC_NS+`CLK_NS-1)/`CLK_NS)
`define PER_CYC ((1*`PCYC_NS+`CLK_NS-1)/`CLK_NS)
`endif

//--- verilog/xfer_pkg.sv
// types for the event triggered transfer controller
// assumes nothing of its surroundings
`default_nettype none
package xfer_pkg;
   typedef enum logic [2:0] {IDLE, RD_INFO, DATA_WAIT, DATA_CAP, STEP, WB}
      xfer_state_t;
endpackage : xfer_pkg
`default_nettype wire
